// file: hdl/aiocr_top.sv
// Purpose: host register bank of an analog I/O board: converter codes,
//   trigger setup, board/queue status, interrupt enables and flags, two ports
// Assumes: strobes one cycle long, never together; pins synchronous to CLOCK_I
// Notes: read data stand only in the cycle after the read strobe
//
// Contract
// - first converter code from offsets C and D
// - synchronous option holds first code until second
// - write-only synchronous bit, offset 10 bit 0
// - second converter code from offsets E and F
// - trigger origin in offset 11 bits 1..0
// - bit 2 start type, bit 3 edge
// - bit 4 selects counter zero clock
// - offset 12 bits 2..0 report jumpers
// - offset 12 bits 3,4 report output ranges
// - offset 12 bits 7..5 report queue state
// - offset 13 write sets four interrupt enables
// - enabled condition raises an interrupt
// - offset 13 read returns interrupt flags
// - offset 13 read clears flags set at read
// - offset 14 is first digital port
// - offset 15 is second digital port
// - direction at 17 needs qualifier bit 7
// - software mode: write to 1 starts once
// - other modes start from counter two output
`default_nettype none
module aiocr_top #(
  parameter int CODE_W = aiocr_pkg::CODE_W
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // register port
  input wire logic [aiocr_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [aiocr_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [aiocr_pkg::DATA_W-1:0] RDATA_O,
  // converter codes
  output logic [CODE_W-1:0] FIRST_OUTPUT_RANGE_FLAG_CODE_O,
  output logic [CODE_W-1:0] SECOND_OUTPUT_RANGE_FLAG_CODE_O,
  // conversion trigger
  output aiocr_pkg::aiocr_trig_type TRIG_CONFIG_O,
  input wire logic COUNTER_TWO_OUT_I,
  output logic AD_START_O,
  // board straps and queue state
  input wire logic BIPOLAR_JUMPER_I,
  input wire logic SINGLE_ENDED_JUMPER_I,
  input wire logic AMPLIFICATION_JUMPER_FLAG_I,
  input wire logic FIRST_OUTPUT_RANGE_FLAG_I,
  input wire logic SECOND_OUTPUT_RANGE_FLAG_I,
  input wire logic QUEUE_NOT_EMPTY_I,
  input wire logic SAMPLE_QUEUE_HALF_N_I,
  input wire logic SAMPLE_QUEUE_FULL_N_I,
  // conversion events
  input wire logic CONVERSION_DONE_I,
  input wire logic SCAN_DONE_I,
  output logic IRQ_O,
  // digital ports
  input wire logic [7:0] PORT_FIRST_LINES_I,
  output logic [7:0] PORT_FIRST_LINES_O,
  output logic PORT_FIRST_LINES_OE_O,
  input wire logic [7:0] PORT_SECOND_LINES_I,
  output logic [7:0] PORT_SECOND_LINES_O,
  output logic PORT_SECOND_LINES_OE_O
);

  logic [7:0] first_output_range_flag_low_reg, first_output_range_flag_low_next;
  logic [7:0] second_output_range_flag_low_reg, second_output_range_flag_low_next;
  logic [CODE_W-1:0] first_output_range_flag_held_reg, first_output_range_flag_held_next;
  logic [CODE_W-1:0] first_output_range_flag_reg, first_output_range_flag_next;
  logic [CODE_W-1:0] second_output_range_flag_reg, second_output_range_flag_next;
  logic simultaneous_reg, simultaneous_next;
  aiocr_pkg::aiocr_trig_type trig_reg, trig_next;
  logic [3:0] int_enable_reg, int_enable_next;
  logic [3:0] int_flag_reg, int_flag_next;
  logic irq_reg, irq_next;
  logic half_prev_reg, half_prev_next;
  logic full_prev_reg, full_prev_next;
  logic counter_prev_reg, counter_prev_next;
  logic start_reg, start_next;
  logic [7:0] port_a_reg, port_a_next;
  logic [7:0] port_b_reg, port_b_next;
  logic dir_a_reg, dir_a_next;
  logic dir_b_reg, dir_b_next;
  logic oe_a_reg, oe_a_next;
  logic oe_b_reg, oe_b_next;
  logic [7:0] rdata_reg, rdata_next;

  logic wr_hit;
  logic half_cond;
  logic full_cond;
  logic counter_edge;
  logic [3:0] int_event;

  always_comb begin
    half_cond = ~SAMPLE_QUEUE_HALF_N_I;
    full_cond = ~SAMPLE_QUEUE_FULL_N_I;
    // edge chosen by the polarity bit
    if (trig_reg.trigger_polarity) begin
      counter_edge = counter_prev_reg & ~COUNTER_TWO_OUT_I;
    end else begin
      counter_edge = ~counter_prev_reg & COUNTER_TWO_OUT_I;
    end
    // level conditions count once, on their way in
    int_event = {full_cond & ~full_prev_reg, half_cond & ~half_prev_reg,
                 SCAN_DONE_I, CONVERSION_DONE_I};
    wr_hit = WR_I;
  end

  always_comb begin
    first_output_range_flag_low_next = first_output_range_flag_low_reg;
    second_output_range_flag_low_next = second_output_range_flag_low_reg;
    first_output_range_flag_held_next = first_output_range_flag_held_reg;
    first_output_range_flag_next = first_output_range_flag_reg;
    second_output_range_flag_next = second_output_range_flag_reg;
    simultaneous_next = simultaneous_reg;
    trig_next = trig_reg;
    int_enable_next = int_enable_reg;
    port_a_next = port_a_reg;
    port_b_next = port_b_reg;
    dir_a_next = dir_a_reg;
    dir_b_next = dir_b_reg;
    start_next = 1'b0;
    half_prev_next = half_cond;
    full_prev_next = full_cond;
    counter_prev_next = COUNTER_TWO_OUT_I;
    if (wr_hit) begin
      case (ADDR_I)
        aiocr_pkg::OFF_SOFT_START: begin
          // any value starts one conversion, only in software mode
          start_next = ({trig_reg.trigger_origin_high, trig_reg.trigger_origin_low}
                        == aiocr_pkg::ORIGIN_SOFTWARE);
        end
        aiocr_pkg::OFF_FIRST_OUTPUT_RANGE_FLAG_LOW: begin
          first_output_range_flag_low_next = WDATA_I;
        end
        aiocr_pkg::OFF_FIRST_OUTPUT_RANGE_FLAG_HIGH: begin
          // the high byte completes the code; upper four bits ignored
          first_output_range_flag_held_next = {WDATA_I[CODE_W-9:0], first_output_range_flag_low_reg};
          if (!simultaneous_reg) begin
            first_output_range_flag_next = {WDATA_I[CODE_W-9:0], first_output_range_flag_low_reg};
          end
        end
        aiocr_pkg::OFF_SECOND_OUTPUT_RANGE_FLAG_LOW: begin
          second_output_range_flag_low_next = WDATA_I;
        end
        aiocr_pkg::OFF_SECOND_OUTPUT_RANGE_FLAG_HIGH: begin
          second_output_range_flag_next = {WDATA_I[CODE_W-9:0], second_output_range_flag_low_reg};
          if (simultaneous_reg) begin
            first_output_range_flag_next = first_output_range_flag_held_reg;
          end
        end
        aiocr_pkg::OFF_DAC_UPDATE: begin
          simultaneous_next = WDATA_I[aiocr_pkg::BIT_SIMULTANEOUS];
        end
        aiocr_pkg::OFF_TRIGGER: begin
          trig_next = {3'h0, WDATA_I[4:0]};
        end
        aiocr_pkg::OFF_INTERRUPT: begin
          int_enable_next = WDATA_I[3:0];
        end
        aiocr_pkg::OFF_PORT_A: begin
          port_a_next = WDATA_I;
        end
        aiocr_pkg::OFF_PORT_B: begin
          port_b_next = WDATA_I;
        end
        aiocr_pkg::OFF_DIRECTION: begin
          // without the qualifier the write is dropped
          if (WDATA_I[aiocr_pkg::BIT_DIR_QUALIFIER]) begin
            dir_a_next = WDATA_I[aiocr_pkg::BIT_DIR_PORT_A];
            dir_b_next = WDATA_I[aiocr_pkg::BIT_DIR_PORT_B];
          end
        end
        default: begin
          start_next = 1'b0;
        end
      endcase
    end
    // timer and external origins both arrive through counter two
    if ({trig_reg.trigger_origin_high, trig_reg.trigger_origin_low}
        != aiocr_pkg::ORIGIN_SOFTWARE && counter_edge) begin
      start_next = 1'b1;
    end
    // enables kept as flops so the pin drivers see no gate in front
    oe_a_next = ~dir_a_next;
    oe_b_next = ~dir_b_next;
  end

  // read path and flag clearing
  always_comb begin
    rdata_next = 8'h00;
    // a flag raised in the clearing cycle survives: set wins
    int_flag_next = int_flag_reg;
    if (RD_I) begin
      case (ADDR_I)
        aiocr_pkg::OFF_STATUS: begin
          rdata_next = {SAMPLE_QUEUE_FULL_N_I, SAMPLE_QUEUE_HALF_N_I,
                        QUEUE_NOT_EMPTY_I,
                        SECOND_OUTPUT_RANGE_FLAG_I, FIRST_OUTPUT_RANGE_FLAG_I,
                        AMPLIFICATION_JUMPER_FLAG_I, SINGLE_ENDED_JUMPER_I,
                        BIPOLAR_JUMPER_I};
        end
        aiocr_pkg::OFF_INTERRUPT: begin
          rdata_next = {int_flag_reg, 4'h0};
          int_flag_next = aiocr_pkg::RST_INT;
        end
        aiocr_pkg::OFF_PORT_A: begin
          rdata_next = dir_a_reg ? PORT_FIRST_LINES_I : port_a_reg;
        end
        aiocr_pkg::OFF_PORT_B: begin
          rdata_next = dir_b_reg ? PORT_SECOND_LINES_I : port_b_reg;
        end
        default: begin
          // write-only and unmapped offsets read as zero
          rdata_next = 8'h00;
        end
      endcase
    end
    int_flag_next = int_flag_next | (int_event & int_enable_reg);
    irq_next = |int_flag_next;
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      first_output_range_flag_low_reg <= 8'h00;
      second_output_range_flag_low_reg <= 8'h00;
      first_output_range_flag_held_reg <= aiocr_pkg::RST_CODE;
      first_output_range_flag_reg <= aiocr_pkg::RST_CODE;
      second_output_range_flag_reg <= aiocr_pkg::RST_CODE;
      simultaneous_reg <= 1'b0;
      trig_reg <= aiocr_pkg::RST_TRIG;
      int_enable_reg <= aiocr_pkg::RST_INT;
      int_flag_reg <= aiocr_pkg::RST_INT;
      irq_reg <= 1'b0;
      half_prev_reg <= 1'b0;
      full_prev_reg <= 1'b0;
      counter_prev_reg <= 1'b0;
      start_reg <= 1'b0;
      port_a_reg <= aiocr_pkg::RST_PORT;
      port_b_reg <= aiocr_pkg::RST_PORT;
      dir_a_reg <= aiocr_pkg::RST_DIR_INPUT;
      dir_b_reg <= aiocr_pkg::RST_DIR_INPUT;
      oe_a_reg <= ~aiocr_pkg::RST_DIR_INPUT;
      oe_b_reg <= ~aiocr_pkg::RST_DIR_INPUT;
      rdata_reg <= 8'h00;
    end else begin
      first_output_range_flag_low_reg <= first_output_range_flag_low_next;
      second_output_range_flag_low_reg <= second_output_range_flag_low_next;
      first_output_range_flag_held_reg <= first_output_range_flag_held_next;
      first_output_range_flag_reg <= first_output_range_flag_next;
      second_output_range_flag_reg <= second_output_range_flag_next;
      simultaneous_reg <= simultaneous_next;
      trig_reg <= trig_next;
      int_enable_reg <= int_enable_next;
      int_flag_reg <= int_flag_next;
      irq_reg <= irq_next;
      half_prev_reg <= half_prev_next;
      full_prev_reg <= full_prev_next;
      counter_prev_reg <= counter_prev_next;
      start_reg <= start_next;
      port_a_reg <= port_a_next;
      port_b_reg <= port_b_next;
      dir_a_reg <= dir_a_next;
      dir_b_reg <= dir_b_next;
      oe_a_reg <= oe_a_next;
      oe_b_reg <= oe_b_next;
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA_O = rdata_reg;
  assign FIRST_OUTPUT_RANGE_FLAG_CODE_O = first_output_range_flag_reg;
  assign SECOND_OUTPUT_RANGE_FLAG_CODE_O = second_output_range_flag_reg;
  assign TRIG_CONFIG_O = trig_reg;
  assign AD_START_O = start_reg;
  assign IRQ_O = irq_reg;
  assign PORT_FIRST_LINES_O = port_a_reg;
  assign PORT_FIRST_LINES_OE_O = oe_a_reg;
  assign PORT_SECOND_LINES_O = port_b_reg;
  assign PORT_SECOND_LINES_OE_O = oe_b_reg;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_first_output_range_flag_high_write;
    WR_I && ADDR_I == aiocr_pkg::OFF_FIRST_OUTPUT_RANGE_FLAG_HIGH;
  endsequence

  sequence s_second_output_range_flag_high_write;
    WR_I && ADDR_I == aiocr_pkg::OFF_SECOND_OUTPUT_RANGE_FLAG_HIGH;
  endsequence

  AST_FIRST_OUTPUT_RANGE_FLAG_DIRECT: assert property (
    s_first_output_range_flag_high_write ##0 !simultaneous_reg |=>
      FIRST_OUTPUT_RANGE_FLAG_CODE_O == {$past(WDATA_I[3:0]), $past(first_output_range_flag_low_reg)})
    else $error("first converter code not applied on high byte write");

  AST_FIRST_OUTPUT_RANGE_FLAG_HELD: assert property (
    simultaneous_reg && !(WR_I && ADDR_I == aiocr_pkg::OFF_SECOND_OUTPUT_RANGE_FLAG_HIGH) |=> $stable(FIRST_OUTPUT_RANGE_FLAG_CODE_O))
    else $error("first converter moved without a second converter write");

  AST_SIMUL_BOTH: assert property (
    s_second_output_range_flag_high_write ##0 simultaneous_reg |=> FIRST_OUTPUT_RANGE_FLAG_CODE_O == $past(first_output_range_flag_held_reg))
    else $error("simultaneous update missed first converter");

  AST_SECOND_OUTPUT_RANGE_FLAG_CODE: assert property (
    s_second_output_range_flag_high_write |=> SECOND_OUTPUT_RANGE_FLAG_CODE_O == {$past(WDATA_I[3:0]), $past(second_output_range_flag_low_reg)})
    else $error("second converter code wrong");

  AST_SOFT_START: assert property (
    WR_I && ADDR_I == aiocr_pkg::OFF_SOFT_START && TRIG_CONFIG_O[1:0] == 2'h0
      |=> AD_START_O ##1
        (!AD_START_O || $past(WR_I && ADDR_I == aiocr_pkg::OFF_SOFT_START)))
    else $error("software start not a single pulse");

  AST_NO_SOFT_START: assert property (
    TRIG_CONFIG_O[1:0] == aiocr_pkg::ORIGIN_SOFTWARE |=>
      !AD_START_O || $past(WR_I && ADDR_I == aiocr_pkg::OFF_SOFT_START))
    else $error("start pulse without software write in software mode");

  AST_STATUS_READ: assert property (
    RD_I && ADDR_I == aiocr_pkg::OFF_STATUS |=>
      RDATA_O[7:5] == {$past(SAMPLE_QUEUE_FULL_N_I), $past(SAMPLE_QUEUE_HALF_N_I),
                       $past(QUEUE_NOT_EMPTY_I)})
    else $error("queue state misreported");

  AST_FLAG_CLEAR: assert property (
    RD_I && ADDR_I == aiocr_pkg::OFF_INTERRUPT && int_event == 4'h0 |=>
      int_flag_reg == 4'h0 ##1 RDATA_O == 8'h00 || $past(RD_I))
    else $error("interrupt flags not cleared by read");

  AST_IRQ_RAISE: assert property (
    CONVERSION_DONE_I && int_enable_reg[0] |=> int_flag_reg[0] && IRQ_O)
    else $error("enabled conversion event raised no interrupt");

  AST_DIR_QUAL: assert property (
    WR_I && ADDR_I == aiocr_pkg::OFF_DIRECTION && !WDATA_I[7] |=>
      $stable(PORT_FIRST_LINES_OE_O) && $stable(PORT_SECOND_LINES_OE_O))
    else $error("direction changed without qualifier");

  AST_COUNTER_START: assert property (
    TRIG_CONFIG_O[1:0] != aiocr_pkg::ORIGIN_SOFTWARE && (TRIG_CONFIG_O.trigger_polarity ?
      $fell(COUNTER_TWO_OUT_I) : $rose(COUNTER_TWO_OUT_I)) |=> AD_START_O)
    else $error("counter two edge gave no start");

  AST_TRIG_WRITE: assert property (
    WR_I && ADDR_I == aiocr_pkg::OFF_TRIGGER |=>
      TRIG_CONFIG_O == {3'h0, $past(WDATA_I[4:0])})
    else $error("trigger setup not taken as written");

  AST_ENABLE_WRITE: assert property (
    WR_I && ADDR_I == aiocr_pkg::OFF_INTERRUPT |=> int_enable_reg == $past(WDATA_I[3:0]))
    else $error("interrupt enables not taken as written");

  AST_FLAG_READ: assert property (
    RD_I && ADDR_I == aiocr_pkg::OFF_INTERRUPT |=>
      RDATA_O[aiocr_pkg::INT_FLAG_LSB +: aiocr_pkg::INT_COUNT] == $past(int_flag_reg)
        && RDATA_O[3:0] == 4'h0)
    else $error("interrupt flags misreported");

  AST_STRAP_READ: assert property (
    RD_I && ADDR_I == aiocr_pkg::OFF_STATUS |=>
      RDATA_O[4:0] == {$past(SECOND_OUTPUT_RANGE_FLAG_I), $past(FIRST_OUTPUT_RANGE_FLAG_I),
                       $past(AMPLIFICATION_JUMPER_FLAG_I), $past(SINGLE_ENDED_JUMPER_I),
                       $past(BIPOLAR_JUMPER_I)})
    else $error("jumper or range straps misreported");

  AST_WO_READ_ZERO: assert property (
    RD_I && (ADDR_I == aiocr_pkg::OFF_DAC_UPDATE || ADDR_I == aiocr_pkg::OFF_TRIGGER) |=>
      RDATA_O == 8'h00)
    else $error("write-only offset read back nonzero");

  AST_PORT_A_READ: assert property (
    RD_I && ADDR_I == aiocr_pkg::OFF_PORT_A |=> RDATA_O == ($past(PORT_FIRST_LINES_OE_O) ?
      $past(PORT_FIRST_LINES_O) : $past(PORT_FIRST_LINES_I)))
    else $error("first port read back wrong");

  AST_PORT_B_READ: assert property (
    RD_I && ADDR_I == aiocr_pkg::OFF_PORT_B |=> RDATA_O == ($past(PORT_SECOND_LINES_OE_O) ?
      $past(PORT_SECOND_LINES_O) : $past(PORT_SECOND_LINES_I)))
    else $error("second port read back wrong");

endmodule
`default_nettype wire

// file: hdl/aiocr_pkg.sv
// Purpose: constants and types shared by the analog I/O control register bank
// Assumes: byte-wide register port, 5-bit byte offsets
// Notes: offsets are the board's byte offsets from its base address
`default_nettype none
package aiocr_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int CODE_W = 12;

  // register offsets
  localparam logic [4:0] OFF_SOFT_START = 5'h01;
  localparam logic [4:0] OFF_FIRST_OUTPUT_RANGE_FLAG_LOW = 5'h0C;
  localparam logic [4:0] OFF_FIRST_OUTPUT_RANGE_FLAG_HIGH = 5'h0D;
  localparam logic [4:0] OFF_SECOND_OUTPUT_RANGE_FLAG_LOW = 5'h0E;
  localparam logic [4:0] OFF_SECOND_OUTPUT_RANGE_FLAG_HIGH = 5'h0F;
  localparam logic [4:0] OFF_DAC_UPDATE = 5'h10;
  localparam logic [4:0] OFF_TRIGGER = 5'h11;
  localparam logic [4:0] OFF_STATUS = 5'h12;
  localparam logic [4:0] OFF_INTERRUPT = 5'h13;
  localparam logic [4:0] OFF_PORT_A = 5'h14;
  localparam logic [4:0] OFF_PORT_B = 5'h15;
  localparam logic [4:0] OFF_DIRECTION = 5'h17;

  // field positions
  localparam int BIT_SIMULTANEOUS = 0;
  localparam int BIT_DIR_QUALIFIER = 7;
  localparam int BIT_DIR_PORT_A = 4;
  localparam int BIT_DIR_PORT_B = 1;
  localparam int INT_FLAG_LSB = 4;
  localparam int INT_COUNT = 4;

  // trigger origin encodings
  localparam logic [1:0] ORIGIN_SOFTWARE = 2'h0;
  localparam logic [1:0] ORIGIN_TIMER = 2'h1;
  localparam logic [1:0] ORIGIN_EXTERNAL = 2'h2;

  // values after reset
  localparam logic [11:0] RST_CODE = 12'h000;
  localparam logic [3:0] RST_INT = 4'h0;
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic RST_DIR_INPUT = 1'b1;

  // conversion trigger configuration, laid out as written to its offset
  typedef struct packed {
    logic [2:0] unused;
    logic counter_zero_tick_select;
    logic trigger_polarity;
    logic single_or_scan_select;
    logic trigger_origin_high;
    logic trigger_origin_low;
  } aiocr_trig_type;

  localparam aiocr_trig_type RST_TRIG = 8'h00;
endpackage
`default_nettype wire

// file: sim/aiocr_host_model.sv
// Purpose: host master model for the register port of the analog I/O bank
// Assumes: one strobe per access, changed right after a rising edge
// Notes: one idle cycle between accesses keeps the strobes from merging
`default_nettype none
module aiocr_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic [4:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    addr_o = 5'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // returns just after the taking edge so outputs have settled
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Purpose: self-checking bench for the analog I/O register bank
// Assumes: register port driven by the host model
// Notes: board straps, queue levels and events are driven here
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, sts, r, pa_o, pb_o;
  logic [7:0] ext_a = 8'h69;
  logic [7:0] ext_b = 8'h96;
  logic wr, rd, ad_start, irq, pa_oe, pb_oe;
  logic [2:0] ev = 3'h0;
  logic [11:0] first_output_range_flag, second_output_range_flag;
  aiocr_pkg::aiocr_trig_type trig;
  wire logic [7:0] pa_i = pa_oe ? pa_o : ext_a;
  wire logic [7:0] pb_i = pb_oe ? pb_o : ext_b;
  int fails = 0;
  int check_count = 0;
  int starts = 0;
  int s;
  logic [7:0] tv [3] = '{8'hFC, 8'h15, 8'hEA};
  logic [7:0] tc [3] = '{8'h00, 8'h01, 8'h0A};

  initial forever #25 clk = ~clk;

  aiocr_top u_aiocr_top (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FIRST_OUTPUT_RANGE_FLAG_CODE_O(first_output_range_flag), .SECOND_OUTPUT_RANGE_FLAG_CODE_O(second_output_range_flag),
    .TRIG_CONFIG_O(trig), .COUNTER_TWO_OUT_I(ev[2]), .AD_START_O(ad_start),
    .BIPOLAR_JUMPER_I(sts[0]), .SINGLE_ENDED_JUMPER_I(sts[1]),
    .AMPLIFICATION_JUMPER_FLAG_I(sts[2]), .FIRST_OUTPUT_RANGE_FLAG_I(sts[3]),
    .SECOND_OUTPUT_RANGE_FLAG_I(sts[4]), .QUEUE_NOT_EMPTY_I(sts[5]),
    .SAMPLE_QUEUE_HALF_N_I(sts[6]), .SAMPLE_QUEUE_FULL_N_I(sts[7]),
    .CONVERSION_DONE_I(ev[0]), .SCAN_DONE_I(ev[1]), .IRQ_O(irq),
    .PORT_FIRST_LINES_I(pa_i), .PORT_FIRST_LINES_O(pa_o), .PORT_FIRST_LINES_OE_O(pa_oe),
    .PORT_SECOND_LINES_I(pb_i), .PORT_SECOND_LINES_O(pb_o), .PORT_SECOND_LINES_OE_O(pb_oe));

  aiocr_host_model u_aiocr_host_model (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  // counting every high cycle also catches a start pulse that sticks
  always @(posedge clk) if (ad_start === 1'b1) starts <= starts + 1;

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [4:0] a, input logic [7:0] d);
    u_aiocr_host_model.wr(a, d);
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    u_aiocr_host_model.rd(a, r);
    chk(r, e);
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // queue levels rise in the same cycle as both event pulses
  task automatic fire();
    @(posedge clk);
    sts <= 8'hC0;
    @(posedge clk);
    sts <= 8'h00;
    ev[1:0] <= 2'b11;
    @(posedge clk);
    ev[1:0] <= 2'b00;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    sts = 8'hC0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(first_output_range_flag | second_output_range_flag, 12'h000);
    chk({pa_oe, pb_oe, irq, trig}, 12'h000);
    rc(5'h13, 8'h00);
    $display("end reset");
    w(5'h0C, 8'h34);
    w(5'h0D, 8'hF2);
    chk(first_output_range_flag, 12'h234);
    w(5'h0E, 8'hCD);
    w(5'h0F, 8'h0A);
    chk(second_output_range_flag, 12'hACD);
    w(5'h10, 8'h01);
    w(5'h0C, 8'h11);
    w(5'h0D, 8'h01);
    chk(first_output_range_flag, 12'h234);
    w(5'h0E, 8'h22);
    w(5'h0F, 8'h02);
    chk(first_output_range_flag, 12'h111);
    chk(second_output_range_flag, 12'h222);
    rc(5'h10, 8'h00);
    $display("end codes");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      sts <= tv[k];
      w(5'h11, tv[k]);
      chk(trig, tv[k] & 8'h1F);
      rc(5'h12, tv[k]);
    end
    $display("end trigger and status");
    // each mode sees a soft write and a counter pulse; only one may start
    for (int k = 0; k < 3; k++) begin
      w(5'h11, tc[k]);
      s = starts;
      w(5'h01, 8'h5A);
      pulse(2);
      chk(12'(starts - s), 12'h001);
    end
    $display("end start");
    for (int b = 0; b < 4; b++) begin
      w(5'h13, 8'hF0 | (8'h01 << b));
      fire();
      chk(irq, 1'b1);
      rc(5'h13, 8'h10 << b);
      chk(irq, 1'b0);
    end
    w(5'h13, 8'h0F);
    fire();
    rc(5'h13, 8'hF0);
    rc(5'h13, 8'h00);
    w(5'h13, 8'h00);
    fire();
    chk(irq, 1'b0);
    $display("end interrupts");
    // second reset in mid-run, with flags, enables and the sync bit all set
    w(5'h13, 8'h0F);
    w(5'h10, 8'h01);
    fire();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({irq, trig}, 12'h000);
    chk(first_output_range_flag | second_output_range_flag, 12'h000);
    rc(5'h13, 8'h00);
    fire();
    chk(irq, 1'b0);
    w(5'h0C, 8'h5A);
    w(5'h0D, 8'h03);
    chk(first_output_range_flag, 12'h35A);
    $display("end second reset");
    w(5'h17, 8'h00);
    chk({pa_oe, pb_oe}, 2'b00);
    w(5'h14, 8'hA5);
    w(5'h15, 8'h3C);
    rc(5'h14, 8'h69);
    w(5'h17, 8'h80);
    chk({pa_oe, pb_oe, pa_o}, 12'h3A5);
    chk(pb_o, 8'h3C);
    rc(5'h14, 8'hA5);
    rc(5'h15, 8'h3C);
    w(5'h17, 8'h82);
    chk({pa_oe, pb_oe}, 2'b10);
    rc(5'h15, 8'h96);
    rc(5'h16, 8'h00);
    rc(5'h11, 8'h00);
    $display("end ports");
    tally_and_finish();
  end
endmodule
`default_nettype wire
